// ### rtl/psro_top.sv
// periodic serial record transmitter with apb registers
//
// The implementer's own choices: the register addresses and the APB register port.
module psro_top
    import psro_pkg::*;
#(
    parameter int CLK_HZ = 100_000_000, // pclk rate
    parameter int TICK_CYCLES = CLK_HZ, // cycles per one-second tick
    parameter int FIFO_DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic txd
);

    // ****************************************************************
    // apb slave
    // ****************************************************************
    logic [CTL_BITS-1:0] ctrl_q; // configuration bits
    logic [15:0] field_q [NUM_FIELDS]; // measurement value table
    logic [31:0] count_q; // records completed
    logic busy_q; // record in progress
    logic pend_q; // expiry waiting for service
    logic setup; // setup phase seen
    logic wr_en; // write completes this edge
    logic field_hit; // address in value table
    logic [3:0] field_idx; // table index
    logic [31:0] rd_d; // read mux
    logic err_d; // unmapped address, or write to status or count

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign field_hit = (paddr[7:6] == ADDR_FIELD0[7:6]) && (paddr[1:0] == 2'b00);
    assign field_idx = paddr[5:2];

    // read data and error decode
    always_comb
    begin
        rd_d = '0;
        err_d = 1'b0;
        if (paddr == ADDR_CTRL)
            rd_d = {{(32-CTL_BITS){1'b0}}, ctrl_q};
        else if (paddr == ADDR_STATUS)
            rd_d = {29'h0, txd, pend_q, busy_q};
        else if (paddr == ADDR_COUNT)
            rd_d = count_q;
        else if (field_hit)
            rd_d = {16'h0, field_q[field_idx]};
        else
            err_d = 1'b1;
        // status and count refuse writes
        if (pwrite && (paddr == ADDR_STATUS || paddr == ADDR_COUNT))
            err_d = 1'b1;
    end

    // answer one cycle after setup, no wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && err_d;
            if (setup && !pwrite)
                prdata <= rd_d;
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= CTRL_RESET[CTL_BITS-1:0];
        else if (wr_en && paddr == ADDR_CTRL)
            ctrl_q <= pwdata[CTL_BITS-1:0];
    end

    // value table written by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            field_q <= '{default: '0};
        else if (wr_en && field_hit)
            field_q[field_idx] <= pwdata[15:0];
    end

    // ****************************************************************
    // interval timer
    // ****************************************************************
    logic [31:0] tick_cnt_q; // cycles within the second
    logic [16:0] sec_cnt_q; // seconds within the interval
    logic [2:0] cyc_q; // last cycle setting
    logic [16:0] sec_lim; // interval length
    logic tick; // one-second enable
    logic expire; // interval ended

    // interval length from setting
    always_comb
    begin
        case (ctrl_q[CTL_CYC_LO +: 3])
            CYC_10S: sec_lim = SEC_10S;
            CYC_1M: sec_lim = SEC_1M;
            CYC_10M: sec_lim = SEC_10M;
            CYC_1H: sec_lim = SEC_1H;
            CYC_1D: sec_lim = SEC_1D;
            default: sec_lim = '0;
        endcase
    end

    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    assign expire = tick && (sec_lim != '0) && (sec_cnt_q == sec_lim - 1'b1);

    // second divider and seconds counter, restarted on setting change
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_q <= '0;
            sec_cnt_q <= '0;
            cyc_q <= CYC_OFF;
        end
        else
        begin
            cyc_q <= ctrl_q[CTL_CYC_LO +: 3];
            if (cyc_q != ctrl_q[CTL_CYC_LO +: 3] || tick)
                tick_cnt_q <= '0;
            else
                tick_cnt_q <= tick_cnt_q + 1'b1;
            if (cyc_q != ctrl_q[CTL_CYC_LO +: 3] || expire)
                sec_cnt_q <= '0;
            else if (tick)
                sec_cnt_q <= sec_cnt_q + 1'b1;
        end
    end

    // ****************************************************************
    // record formatter
    // ****************************************************************
    psro_stream_if #(.W(8)) fmt_s ();
    psro_stream_if #(.W(8)) line_s ();
    psro_fmt_t fmt_q;
    logic [3:0] pos_q; // current field
    logic [1:0] nib_q; // current hex digit, high first
    logic [3:0] last_pos; // last field of chosen set
    logic [3:0] nib; // nibble being sent
    logic tx_idle; // line sender idle
    logic start; // begin a record

    assign last_pos = ctrl_q[CTL_LONG] ? POS_LONG_LAST : POS_SHORT_LAST;
    assign nib = 4'(field_q[pos_q] >> {nib_q, 2'b00});
    // only one record at a time
    assign start = pend_q && !busy_q;

    // byte offered to the fifo
    always_comb
    begin
        fmt_s.valid = 1'b1;
        fmt_s.data = ASCII_LF;
        case (fmt_q)
            FMT_DIGIT: fmt_s.data = (nib < 4'ha) ? ASCII_ZERO + 8'(nib)
                                                 : ASCII_A_M10 + 8'(nib);
            FMT_DELIM: fmt_s.data = ASCII_DELIM;
            FMT_CR: fmt_s.data = ASCII_CR;
            FMT_LF: fmt_s.data = ASCII_LF;
            default: fmt_s.valid = 1'b0;
        endcase
    end

    // formatter sequence, stalls while fifo is full
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fmt_q <= FMT_IDLE;
            pos_q <= '0;
            nib_q <= '0;
        end
        else
        begin
            case (fmt_q)
                FMT_IDLE:
                begin
                    if (start)
                    begin
                        fmt_q <= FMT_DIGIT;
                        pos_q <= '0;
                        nib_q <= 2'h3;
                    end
                end
                FMT_DIGIT:
                begin
                    if (fmt_s.ready)
                    begin
                        nib_q <= nib_q - 1'b1;
                        if (nib_q == 2'h0)
                            fmt_q <= FMT_DELIM;
                    end
                end
                FMT_DELIM:
                begin
                    if (fmt_s.ready)
                    begin
                        nib_q <= 2'h3;
                        if (pos_q != last_pos && pos_q != POS_ERR)
                        begin
                            pos_q <= pos_q + 1'b1;
                            fmt_q <= FMT_DIGIT;
                        end
                        else if (pos_q == last_pos && ctrl_q[CTL_SEND_ERR])
                        begin
                            pos_q <= POS_ERR;
                            fmt_q <= FMT_DIGIT;
                        end
                        else
                            fmt_q <= ctrl_q[CTL_CRLF] ? FMT_CR : FMT_LF;
                    end
                end
                FMT_CR:
                begin
                    if (fmt_s.ready)
                        fmt_q <= FMT_LF;
                end
                FMT_LF:
                begin
                    if (fmt_s.ready)
                        fmt_q <= FMT_DRAIN;
                end
                // wait until the line has sent every byte
                FMT_DRAIN:
                begin
                    if (!line_s.valid && tx_idle)
                        fmt_q <= FMT_IDLE;
                end
                default: fmt_q <= FMT_IDLE;
            endcase
        end
    end

    // busy flag, pending expiry and record count; expiry beats service
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q <= 1'b0;
            pend_q <= 1'b0;
            count_q <= '0;
        end
        else
        begin
            if (start)
                busy_q <= 1'b1;
            else if (fmt_q == FMT_DRAIN && !line_s.valid && tx_idle)
                busy_q <= 1'b0;
            if (fmt_q == FMT_DRAIN && !line_s.valid && tx_idle)
                count_q <= count_q + 1'b1;
            if (sec_lim == '0)
                pend_q <= 1'b0;
            else if (expire)
                pend_q <= 1'b1;
            else if (start)
                pend_q <= 1'b0;
        end
    end

    psro_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .wr(fmt_s.snk),
        .rd(line_s.src)
    );

    // ****************************************************************
    // serial line sender
    // ****************************************************************
    psro_tx_t tx_q;
    logic [7:0] sh_q; // data shift register
    logic [2:0] bit_q; // bit counter
    logic [19:0] div_q; // baud divider
    logic [19:0] div_lim; // cycles per bit
    logic [7:0] cfg_q; // framing latched per byte
    logic par_q; // running parity
    logic bit_end; // one-bit enable
    int rate;

    // cycles per bit from selected rate
    always_comb
    begin
        case (ctrl_q[CTL_BAUD_LO +: 3])
            3'h1: rate = BAUD_2400;
            3'h2: rate = BAUD_4800;
            3'h3: rate = BAUD_9600;
            3'h4: rate = BAUD_19200;
            default: rate = BAUD_1200;
        endcase
        div_lim = 20'((CLK_HZ + rate / 2) / rate);
    end

    assign bit_end = (div_q == div_lim - 1'b1);
    assign tx_idle = (tx_q == TX_IDLE);
    assign line_s.ready = tx_idle;

    // baud divider runs only inside a frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_q <= '0;
        else if (tx_idle || bit_end)
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end

    // frame with start, data, parity and stop bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_q <= TX_IDLE;
            txd <= 1'b1;
            sh_q <= '0;
            bit_q <= '0;
            cfg_q <= '0;
            par_q <= 1'b0;
        end
        else
        begin
            case (tx_q)
                TX_IDLE:
                begin
                    txd <= 1'b1;
                    if (line_s.valid)
                    begin
                        sh_q <= line_s.data;
                        cfg_q <= {3'h0, ctrl_q[CTL_PAR_LO +: 2],
                                  ctrl_q[CTL_STOP2], ctrl_q[CTL_DATA8], 1'b0};
                        par_q <= 1'b0;
                        txd <= 1'b0;
                        tx_q <= TX_START;
                    end
                end
                TX_START:
                begin
                    if (bit_end)
                    begin
                        txd <= sh_q[0];
                        par_q <= sh_q[0];
                        sh_q <= sh_q >> 1;
                        bit_q <= '0;
                        tx_q <= TX_DATA;
                    end
                end
                TX_DATA:
                begin
                    if (bit_end)
                    begin
                        bit_q <= bit_q + 1'b1;
                        if (bit_q != (cfg_q[1] ? 3'h7 : 3'h6))
                        begin
                            txd <= sh_q[0];
                            par_q <= par_q ^ sh_q[0];
                            sh_q <= sh_q >> 1;
                        end
                        else if (cfg_q[4:3] == PAR_NONE)
                        begin
                            txd <= 1'b1;
                            bit_q <= '0;
                            tx_q <= TX_STOP;
                        end
                        else
                        begin
                            // odd parity makes total ones odd
                            txd <= par_q ^ (cfg_q[4:3] == PAR_ODD);
                            tx_q <= TX_PARITY;
                        end
                    end
                end
                TX_PARITY:
                begin
                    if (bit_end)
                    begin
                        txd <= 1'b1;
                        bit_q <= '0;
                        tx_q <= TX_STOP;
                    end
                end
                TX_STOP:
                begin
                    if (bit_end)
                    begin
                        bit_q <= bit_q + 1'b1;
                        if (bit_q == {2'b00, cfg_q[2]})
                            tx_q <= TX_IDLE;
                    end
                end
                default: tx_q <= TX_IDLE;
            endcase
        end
    end

endmodule : psro_top

// ### common/psro_pkg.sv
// constants shared by the periodic serial record transmitter
package psro_pkg;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00; // configuration, read/write
    localparam logic [7:0] ADDR_STATUS = 8'h04; // block state, read only
    localparam logic [7:0] ADDR_COUNT = 8'h08; // records sent, read only
    localparam logic [7:0] ADDR_FIELD0 = 8'h40; // first measurement word
    localparam int NUM_FIELDS = 16; // words in the value table
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000; // all off after reset

    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int CTL_CYC_LO = 0; // cycle time select, 3 bits
    localparam int CTL_LONG = 3; // long record size
    localparam int CTL_BAUD_LO = 4; // baud select, 3 bits
    localparam int CTL_DATA8 = 7; // 8 data bits, else 7
    localparam int CTL_STOP2 = 8; // two stop bits, else one
    localparam int CTL_PAR_LO = 9; // parity select, 2 bits
    localparam int CTL_SEND_ERR = 11; // append error code word
    localparam int CTL_CRLF = 12; // CR LF ending, else LF
    localparam int CTL_BITS = 13; // implemented control bits

    // ****************************************************************
    // setting encodings
    // ****************************************************************
    localparam logic [2:0] CYC_OFF = 3'h0;
    localparam logic [2:0] CYC_10S = 3'h1;
    localparam logic [2:0] CYC_1M = 3'h2;
    localparam logic [2:0] CYC_10M = 3'h3;
    localparam logic [2:0] CYC_1H = 3'h4;
    localparam logic [2:0] CYC_1D = 3'h5;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;

    // interval lengths in seconds
    localparam logic [16:0] SEC_10S = 17'd10;
    localparam logic [16:0] SEC_1M = 17'd60;
    localparam logic [16:0] SEC_10M = 17'd600;
    localparam logic [16:0] SEC_1H = 17'd3600;
    localparam logic [16:0] SEC_1D = 17'd86400;

    // baud rates selectable
    localparam int BAUD_1200 = 1200;
    localparam int BAUD_2400 = 2400;
    localparam int BAUD_4800 = 4800;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_19200 = 19200;

    // ****************************************************************
    // record layout
    // ****************************************************************
    localparam logic [3:0] POS_SHORT_LAST = 4'h7; // relay state ends short set
    localparam logic [3:0] POS_LONG_LAST = 4'he; // limit relay ends long set
    localparam logic [3:0] POS_ERR = 4'hf; // error code word
    localparam logic [7:0] ASCII_DELIM = 8'h2c; // comma
    localparam logic [7:0] ASCII_CR = 8'h0d;
    localparam logic [7:0] ASCII_LF = 8'h0a;
    localparam logic [7:0] ASCII_ZERO = 8'h30;
    localparam logic [7:0] ASCII_A_M10 = 8'h37; // 'A' minus ten

    // formatter and line states
    typedef enum logic [2:0] {
        FMT_IDLE = 3'b000,
        FMT_DIGIT = 3'b001,
        FMT_DELIM = 3'b010,
        FMT_CR = 3'b011,
        FMT_LF = 3'b100,
        FMT_DRAIN = 3'b101
    } psro_fmt_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_PARITY = 3'b011,
        TX_STOP = 3'b100
    } psro_tx_t;

endpackage : psro_pkg

// ### common/psro_stream_if.sv
// valid/ready byte stream between formatter, fifo and line sender
interface psro_stream_if #(parameter int W = 8);
    logic valid; // data offered
    logic ready; // data accepted
    logic [W-1:0] data; // payload
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : psro_stream_if

// ### rtl/psro_fifo.sv
// synchronous first-in first-out buffer with valid/ready on both sides
module psro_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    psro_stream_if.snk wr,
    psro_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    // storage and pointers with wrap bit
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic full;
    logic empty;

    // full when pointers differ only in wrap bit
    assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty = (wp_q == rp_q);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rp_q[AW-1:0]];

    // write side
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wp_q <= '0;
        else if (wr.valid && !full)
            wp_q <= wp_q + 1'b1;
    end

    // storage array, no reset needed
    always_ff @(posedge clk)
    begin
        if (wr.valid && !full)
            mem[wp_q[AW-1:0]] <= wr.data;
    end

    // read side
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rp_q <= '0;
        else if (rd.ready && !empty)
            rp_q <= rp_q + 1'b1;
    end

endmodule : psro_fifo

// ### verif/psro_top_checker.sv
// port-level checks of the periodic serial record transmitter
module psro_top_checker
    import psro_pkg::*;
#(
    parameter int CLK_HZ = 100_000_000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic txd
);
    timeunit 1ns;
    timeprecision 1ns;
    // shortest bit time at the fastest rate
    localparam int MIN_BIT = CLK_HZ / 19200;
    logic [31:0] low_q; // cycles the line has been low

    // ****************************************************************
    // helper: length of the current low run
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            low_q <= 32'h0;
        else
            low_q <= txd ? 32'h0 : low_q + 32'h1;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_unmapped_err: assert property (psel && !penable && paddr == 8'h10 |=> pslverr)
        else $error("unmapped access not refused");
    chk_ro_write_err: assert property (
        psel && !penable && pwrite && paddr == ADDR_STATUS |=> pslverr && pready)
        else $error("status write not refused");
    chk_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returns data");
    chk_ctrl_width: assert property (
        pready && psel && !pwrite && paddr == ADDR_CTRL |-> prdata[31:13] == 19'h0 && !pslverr)
        else $error("control read has stray bits");
    chk_start_bit_len: assert property ($rose(txd) |-> low_q >= MIN_BIT)
        else $error("line low shorter than a bit");
    chk_idle_after_reset: assert property ($rose(presetn) |-> txd)
        else $error("line not idle after reset");
endmodule : psro_top_checker

// ### verif/psro_rx_model.sv
// terminal model decoding serial frames
module psro_rx_model
    import psro_pkg::*;
(
    input wire logic pclk,
    input wire logic txd,
    input wire logic [15:0] bit_cyc,
    input wire logic data8,
    input wire logic stop2,
    input wire logic [1:0] par
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rx_q[$]; // characters received
    int bad_count = 0; // framing or parity faults

    // ****************************************************************
    // frame decoder, sampling each bit near its middle
    // ****************************************************************
    // receiver framing match
    initial
    begin
        logic [7:0] b;
        int ones;
        forever
        begin
            @(negedge txd);
            repeat (bit_cyc / 2) @(posedge pclk);
            if (txd !== 1'b0)
                bad_count++;
            b = 8'h00;
            ones = 0;
            for (int k = 0; k < (data8 ? 8 : 7); k++)
            begin
                repeat (bit_cyc) @(posedge pclk);
                b[k] = txd;
                ones += txd;
            end
            if (par != PAR_NONE)
            begin
                repeat (bit_cyc) @(posedge pclk);
                if ((ones + txd) % 2 != (par == PAR_ODD))
                    bad_count++;
            end
            for (int s = 0; s <= stop2; s++)
            begin
                repeat (bit_cyc) @(posedge pclk);
                if (txd !== 1'b1)
                    bad_count++;
            end
            rx_q.push_back(b);
        end
    end
endmodule : psro_rx_model

// ### verif/psro_top_tb.sv
// self-checking bench of the periodic serial record transmitter
module psro_top_tb
    import psro_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic err_q, rx_d8, rx_s2;
    logic [1:0] rx_par;
    logic [15:0] rx_bit;
    int err_count = 0;
    int compares = 0;
    // per-setup table, bit i belongs to setup i
    logic [4:0] lng = 5'b01100, d8 = 5'b11010, s2 = 5'b01010, er = 5'b11000, cr = 5'b01000;
    logic [1:0] pr[5] = '{PAR_NONE, PAR_ODD, PAR_EVEN, PAR_ODD, PAR_EVEN};
    int bauds[5] = '{BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600, BAUD_19200};

    psro_top #(.CLK_HZ(96000), .TICK_CYCLES(10), .FIFO_DEPTH(16)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txd(txd));
    psro_rx_model rx (.pclk(pclk), .txd(txd), .bit_cyc(rx_bit), .data8(rx_d8),
        .stop2(rx_s2), .par(rx_par));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        if (err_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    // a bounded wait that ran out ends the run
    task automatic tmo(input int n, input int lim);
        if (n >= lim)
        begin
            err_count++;
            $display("[ERR] wait expected done seen timeout");
            test_done();
        end
    endtask : tmo

    // one apb transfer, held until pready, then one idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        tmo(n, 50);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic reg_test();
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd_q, CTRL_RESET, "ctrl reset");
        apb(1'b1, ADDR_CTRL, 32'hffff_fff8);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd_q, 32'h0000_1ff8, "ctrl bits");
        apb(1'b0, 8'h10, 32'h0);
        check({31'h0, err_q}, 32'h1, "unmapped err");
        apb(1'b1, ADDR_STATUS, 32'h1);
        check({31'h0, err_q}, 32'h1, "status write err");
        apb(1'b1, ADDR_CTRL, 32'h0);
        for (int f = 0; f < NUM_FIELDS; f++)
            apb(1'b1, ADDR_FIELD0 + 8'(4 * f), 32'hdead_9ab0 + 32'(f));
        apb(1'b0, ADDR_FIELD0, 32'h0);
        check(rd_q, 32'h0000_9ab0, "field width");
    endtask : reg_test

    // one record per setup
    task automatic run_records();
        logic [7:0] exp[$];
        logic [31:0] cfg;
        logic [15:0] v;
        logic [3:0] nib;
        int n;
        for (int i = 0; i < 5; i++)
        begin
            cfg = (32'(i) << CTL_BAUD_LO) | (32'(lng[i]) << CTL_LONG) | (32'(d8[i]) << CTL_DATA8)
                | (32'(s2[i]) << CTL_STOP2) | (32'(pr[i]) << CTL_PAR_LO)
                | (32'(er[i]) << CTL_SEND_ERR) | (32'(cr[i]) << CTL_CRLF);
            rx_bit <= 16'(96000 / bauds[i]);
            rx_d8 <= d8[i];
            rx_s2 <= s2[i];
            rx_par <= pr[i];
            exp = {};
            for (int f = 0; f < 16; f++)
                if (f <= (lng[i] ? POS_LONG_LAST : POS_SHORT_LAST) || (f == 15 && er[i]))
                begin
                    v = 16'h9ab0 + 16'(f);
                    for (int k = 3; k >= 0; k--)
                    begin
                        nib = v[4 * k +: 4];
                        exp.push_back(nib < 10 ? ASCII_ZERO + 8'(nib) : ASCII_A_M10 + 8'(nib));
                    end
                    exp.push_back(ASCII_DELIM);
                end
            if (cr[i])
                exp.push_back(ASCII_CR);
            exp.push_back(ASCII_LF);
            apb(1'b1, ADDR_CTRL, cfg | 32'(CYC_10S));
            n = 0;
            while (txd === 1'b1 && n < 200)
            begin
                @(posedge pclk);
                n++;
            end
            tmo(n, 200);
            check(32'(n >= 90 && n <= 110), 32'h1, "interval");
            apb(1'b1, ADDR_CTRL, cfg);
            n = 0;
            while (rx.rx_q.size() < exp.size() && n < 40000)
            begin
                @(posedge pclk);
                n++;
            end
            tmo(n, 40000);
            repeat (300) @(posedge pclk);
            check(32'(rx.rx_q.size()), 32'(exp.size()), "record length");
            for (int k = 0; k < exp.size(); k++)
                check(32'(rx.rx_q[k]), 32'(exp[k]), "record char");
            check(32'(rx.bad_count), 32'h0, "framing");
            apb(1'b0, ADDR_COUNT, 32'h0);
            check(rd_q, 32'(i + 1), "record count");
            rx.rx_q = {};
        end
    endtask : run_records

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        rx_bit = 16'd80;
        rx_d8 = 1'b0;
        rx_s2 = 1'b0;
        rx_par = PAR_NONE;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reg_test();
        run_records();
        test_done();
    end
endmodule : psro_top_tb

bind psro_top psro_top_checker #(.CLK_HZ(CLK_HZ)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txd(txd));
